// ### bdc_decade_counter.sv
// Operation
// - count appears on four outputs weighted 1, 2, 4, 8.
// - from zero each pulse adds one; tenth pulse returns to zero.
// - count advances only when the pulse input falls high to low; syncClear loads zero.
// - illegal ten goes to eleven, then to four.
// - illegal twelve goes to thirteen, then to four.
// - illegal fourteen goes to fifteen, then to zero.
// - decoder turns four weighted bits into ten lines combinationally.
// - digits zero to nine drive exactly their own line low.
// - codes ten to fifteen leave all ten lines high.
// - counter is followed by the decoder, one active line per legal count.
`timescale 1ns/1ps
module bdc_decade_counter
   import bdc_pkg::*;
#(
   parameter int unsigned DIGITS    = BDC_DIGITS,
   parameter int unsigned MIN_CYCLES = BDC_MIN_PULSE_CYCLES
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 resetn,
   // pulse pin and same-domain clear
   input  wire logic                 countPulse,
   input  wire logic                 syncClear,
   // count and decoded digit
   output wire logic [BDC_WIDTH-1:0] bcdCount,
   output wire logic [DIGITS-1:0]    digitLowN,
   // status
   output wire logic                 countStep,
   output wire logic                 illegalState,
   output wire logic                 rateError
);

   // ---------------------------------------------------------------
   // pin synchroniser and edge detect
   // ---------------------------------------------------------------
   logic [BDC_SYNC_STAGES-1:0] pulseSync_r;
   logic [BDC_SYNC_STAGES-1:0] pulseSync_nxt;
   logic                       pulseSeen_r;
   logic                       pulseSeen_nxt;
   logic                       fallEdge;
   logic                       riseEdge;

   // stage 0 is read only by stage 1
   always_comb begin
      pulseSync_nxt = {pulseSync_r[BDC_SYNC_STAGES-2:0], countPulse};
      pulseSeen_nxt = pulseSync_r[BDC_SYNC_STAGES-1];
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pulseSync_r <= '0;
         pulseSeen_r <= 1'b0;
      end else begin
         pulseSync_r <= pulseSync_nxt;
         pulseSeen_r <= pulseSeen_nxt;
      end
   end

   // the falling edge is the active one; rising is only watched
   assign fallEdge = pulseSeen_r & ~pulseSync_r[BDC_SYNC_STAGES-1];
   assign riseEdge = ~pulseSeen_r & pulseSync_r[BDC_SYNC_STAGES-1];

   // ---------------------------------------------------------------
   // decade state
   // ---------------------------------------------------------------
   bdc_count_t count_r;
   bdc_count_t count_nxt;
   logic       step_r;
   logic       step_nxt;

   // clear wins over a pulse in the same cycle
   always_comb begin
      count_nxt = count_r;
      step_nxt  = 1'b0;
      if (syncClear) begin
         count_nxt = BDC_RESET_COUNT;
      end else if (fallEdge) begin
         count_nxt = bdcNextCount(count_r);
         step_nxt  = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_r <= BDC_RESET_COUNT;
         step_r  <= 1'b0;
      end else begin
         count_r <= count_nxt;
         step_r  <= step_nxt;
      end
   end

   assign bcdCount     = count_r;
   assign countStep    = step_r;
   assign illegalState = (count_r > BDC_LAST_DIGIT);

   // ---------------------------------------------------------------
   // pulse-rate watch
   // ---------------------------------------------------------------
   // the counter still counts too-fast pulses; this only flags them,
   // since the source is the party held to the limit
   logic [BDC_GAP_WIDTH-1:0] gap_r;
   logic [BDC_GAP_WIDTH-1:0] gap_nxt;
   logic                     rate_r;
   logic                     rate_nxt;
   logic                     tooSoon;

   assign tooSoon = fallEdge && (gap_r < BDC_GAP_WIDTH'(MIN_CYCLES));

   // gap saturates at the limit; set wins over clear
   always_comb begin
      gap_nxt  = gap_r;
      rate_nxt = rate_r;
      if (fallEdge) begin
         gap_nxt = BDC_GAP_WIDTH'(1);
      end else if (gap_r < BDC_GAP_WIDTH'(MIN_CYCLES)) begin
         gap_nxt = gap_r + BDC_GAP_WIDTH'(1);
      end
      if (tooSoon) begin
         rate_nxt = 1'b1;
      end else if (syncClear) begin
         rate_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         gap_r  <= BDC_GAP_WIDTH'(MIN_CYCLES);
         rate_r <= 1'b0;
      end else begin
         gap_r  <= gap_nxt;
         rate_r <= rate_nxt;
      end
   end

   assign rateError = rate_r;

   // ---------------------------------------------------------------
   // decoder following the counter
   // ---------------------------------------------------------------
   bdc_digit_decoder #(
      .DIGITS    (DIGITS)
   ) u_decoder (
      .bcdIn     (count_r),
      .digitLowN (digitLowN)
   );

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_fall_advance: assert property (
      fallEdge && !syncClear && (count_r < BDC_LAST_DIGIT)
      |=> count_r == $past(count_r) + 4'h1)
      else $error("count did not advance by one on a falling edge");

   a_nine_wraps: assert property (
      fallEdge && !syncClear && (count_r == BDC_LAST_DIGIT)
      |=> count_r == BDC_RESET_COUNT)
      else $error("count nine did not wrap to zero");

   a_rise_holds: assert property (
      riseEdge && !syncClear |=> $stable(count_r))
      else $error("count changed on a rising edge");

   a_pin_to_step: assert property (
      $fell(countPulse) ##1 !countPulse [*2] |-> ##[0:1] countStep)
      else $error("falling pin edge gave no step within the sync delay");

   a_ten_eleven: assert property (
      (count_r == BDC_BAD_TEN) && fallEdge && !syncClear
      |=> count_r == BDC_BAD_ELEVEN)
      else $error("ten did not go to eleven");

   a_eleven_four: assert property (
      (count_r == BDC_BAD_ELEVEN) && fallEdge && !syncClear
      |=> count_r == BDC_REJOIN_FOUR)
      else $error("eleven did not go to four");

   // flag must follow any fall closer than the pacing limit
   a_rate_flag: assert property (
      tooSoon |=> rateError)
      else $error("too-fast pulse did not raise the rate flag");

   a_twelve_recovery: assert property (
      (count_r == BDC_BAD_TWELVE) && fallEdge && !syncClear
      |=> count_r == BDC_BAD_THIRTN)
      else $error("twelve did not go to thirteen");

   a_thirteen_four: assert property (
      (count_r == BDC_BAD_THIRTN) && fallEdge && !syncClear
      |=> count_r == BDC_REJOIN_FOUR)
      else $error("thirteen did not go to four");

   a_fourteen_path: assert property (
      (count_r == BDC_BAD_FOURTN) && fallEdge && !syncClear
      |=> (count_r == BDC_BAD_FIFTN))
      else $error("fourteen did not go to fifteen");

   a_fifteen_zero: assert property (
      (count_r == BDC_BAD_FIFTN) && fallEdge && !syncClear
      |=> (count_r == BDC_RESET_COUNT) && !illegalState)
      else $error("fifteen did not go to zero");

   a_decode_onehot: assert property (
      (count_r <= BDC_LAST_DIGIT)
      |-> digitLowN == ~(DIGITS'(1) << count_r))
      else $error("legal digit not decoded to its single low line");

   a_decode_idle: assert property (
      illegalState |-> &digitLowN)
      else $error("illegal code drove a digit line low");

   a_clear_zero: assert property (
      syncClear |=> (count_r == BDC_RESET_COUNT) && !countStep)
      else $error("synchronous clear did not load zero");

   c_wrap: cover property (
      (count_r == BDC_LAST_DIGIT) && fallEdge ##1 count_r == BDC_RESET_COUNT);
   c_ten_path: cover property (
      count_r == BDC_BAD_TEN ##[1:200] count_r == BDC_REJOIN_FOUR);
   c_rate_flag: cover property ($rose(rateError));
   c_full_decade: cover property (
      count_r == 4'h1 ##[1:400] count_r == BDC_LAST_DIGIT);

endmodule : bdc_decade_counter

// ### bdc_pkg.sv
package bdc_pkg;

   // ---------------------------------------------------------------
   // widths and counts
   // ---------------------------------------------------------------
   localparam int unsigned BDC_WIDTH       = 4;
   localparam int unsigned BDC_DIGITS      = 10;
   localparam int unsigned BDC_SYNC_STAGES = 2;
   localparam int unsigned BDC_GAP_WIDTH   = 8;

   // ---------------------------------------------------------------
   // count values
   // ---------------------------------------------------------------
   localparam logic [3:0] BDC_RESET_COUNT = 4'h0;
   localparam logic [3:0] BDC_LAST_DIGIT  = 4'h9;
   localparam logic [3:0] BDC_BAD_TEN     = 4'hA;
   localparam logic [3:0] BDC_BAD_ELEVEN  = 4'hB;
   localparam logic [3:0] BDC_BAD_TWELVE  = 4'hC;
   localparam logic [3:0] BDC_BAD_THIRTN  = 4'hD;
   localparam logic [3:0] BDC_BAD_FOURTN  = 4'hE;
   localparam logic [3:0] BDC_BAD_FIFTN   = 4'hF;
   localparam logic [3:0] BDC_REJOIN_FOUR = 4'h4;

   // ---------------------------------------------------------------
   // timing: clock rate and fastest legal pulse rate
   // ---------------------------------------------------------------
   localparam int unsigned BDC_CLOCK_KHZ     = 100000;
   localparam int unsigned BDC_MAX_PULSE_KHZ = 5000;
   // least pulse period, rounded up to whole clock cycles
   localparam int unsigned BDC_MIN_PULSE_CYCLES =
      (BDC_CLOCK_KHZ + BDC_MAX_PULSE_KHZ - 1) / BDC_MAX_PULSE_KHZ;

   typedef logic [BDC_WIDTH-1:0] bdc_count_t;

   // next count for one falling edge, with the recovery paths
   function automatic bdc_count_t bdcNextCount(input bdc_count_t cur);
      bdc_count_t nxt;
      nxt = cur + 4'h1;
      case (cur)
         BDC_LAST_DIGIT: nxt = BDC_RESET_COUNT;
         BDC_BAD_TEN:    nxt = BDC_BAD_ELEVEN;
         BDC_BAD_ELEVEN: nxt = BDC_REJOIN_FOUR;
         BDC_BAD_TWELVE: nxt = BDC_BAD_THIRTN;
         BDC_BAD_THIRTN: nxt = BDC_REJOIN_FOUR;
         BDC_BAD_FOURTN: nxt = BDC_BAD_FIFTN;
         BDC_BAD_FIFTN:  nxt = BDC_RESET_COUNT;
         default:        nxt = cur + 4'h1;
      endcase
      return nxt;
   endfunction : bdcNextCount

endpackage : bdc_pkg

// ### bdc_digit_decoder.sv
`timescale 1ns/1ps
module bdc_digit_decoder
   import bdc_pkg::*;
#(
   parameter int unsigned DIGITS = BDC_DIGITS
) (
   // weighted input
   input  wire logic [BDC_WIDTH-1:0] bcdIn,
   // one line per digit, low when selected
   output wire logic [DIGITS-1:0]    digitLowN
);

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   // pure gates, so codes 10..15 simply match no line
   for (genvar g = 0; g < DIGITS; g++) begin : gen_digit
      assign digitLowN[g] = (bcdIn != BDC_WIDTH'(g));
   end

endmodule : bdc_digit_decoder

// ### bdc_pulse_src.sv
`timescale 1ns/1ps
module bdc_pulse_src (
   // clock
   input  wire logic clock,
   // pulse pin toward the counter
   output logic      countPulse
);
   // ----------------------------------------
   // pulse source
   // ----------------------------------------
   initial countPulse = 1'b0;

   // high phase, counted fall, low phase; gap between falls is highCyc+lowCyc
   // callers keep that gap at or above the legal pacing unless probing the flag
   task automatic pulse(input int unsigned highCyc, input int unsigned lowCyc);
      @(negedge clock);
      countPulse = 1'b1;
      repeat (highCyc) @(negedge clock);
      countPulse = 1'b0;
      repeat (lowCyc - 1) @(negedge clock);
   endtask : pulse
endmodule : bdc_pulse_src

// ### bcd_decade_counter_decoder_tb.sv
`timescale 1ns/1ps
module bcd_decade_counter_decoder_tb;
   import bdc_pkg::*;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   localparam int unsigned MIN_GAP = BDC_MIN_PULSE_CYCLES;
   logic         clock = 1'b0;
   logic         resetn = 1'b0;
   logic         syncClear = 1'b0;
   wire          countPulse;
   wire [3:0]    bcdCount;
   wire [9:0]    digitLowN;
   wire          countStep;
   wire          illegalState;
   wire          rateError;
   bdc_count_t   q[$];
   bdc_count_t   expN = 4'h0;
   bdc_count_t   e;
   logic [31:0]  rng = 32'd26709;
   int           errCount = 0;
   int           checkCount = 0;
   int           cycles = 0;

   bdc_pulse_src bdc_pulse_src_i (.clock(clock), .countPulse(countPulse));
   bdc_decade_counter #(.MIN_CYCLES(MIN_GAP)) bdc_decade_counter_i (
      .clock(clock), .resetn(resetn), .countPulse(countPulse),
      .syncClear(syncClear), .bcdCount(bcdCount), .digitLowN(digitLowN),
      .countStep(countStep), .illegalState(illegalState), .rateError(rateError));

   always #5 clock = ~clock;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xorshift();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xorshift

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic endSim();
      $display("checks %0d mismatches %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : endSim

   // note the expected count, then let the source make the fall
   task automatic step(input int unsigned h, input int unsigned l);
      expN = (expN == 4'h9) ? 4'h0 : expN + 4'h1;
      q.push_back(expN);
      bdc_pulse_src_i.pulse(h, l);
   endtask : step

   // give the sync path time to land every noted step
   task automatic drain();
      logic [9:0] dExp;
      repeat (8) @(negedge clock);
      check("pending steps", q.size(), 0);
      // decode the settled count in the bench and compare with the design's lines
      dExp = (bcdCount > 4'h9) ? 10'h3FF : ~(10'h1 << bcdCount);
      check("decoder", digitLowN, dExp);
   endtask : drain

   // ----------------------------------------
   // output watcher and hang guard
   // ----------------------------------------
   // countStep stands one cycle, so it is sampled at the falling edge
   always @(negedge clock) begin
      if (resetn === 1'b1 && countStep === 1'b1) begin
         if (q.size() == 0) begin
            check("unexpected step", 1, 0);
         end else begin
            e = q.pop_front();
            check("bcdCount", bcdCount, e);
            check("digitLowN", digitLowN, 10'(~(10'h1 << e)));
            check("illegalState", illegalState, 0);
         end
      end
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         check("timeout", 1, 0);
         endSim();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(negedge clock);
      check("reset count", bcdCount, 0);
      check("reset digit", digitLowN, 10'h3FE);
      check("reset rate", rateError, 0);
      resetn = 1'b1;
      $display("reset checks done");
      // random legal spacing, shortest gap exactly at the limit
      for (int i = 0; i < 23; i++) begin
         rng = xorshift();
         step(MIN_GAP / 2 + rng % 5, MIN_GAP / 2 + (rng >> 8) % 5);
      end
      drain();
      check("rate legal", rateError, 0);
      $display("wrap counting done");
      step(2, 2);
      step(2, 2);
      drain();
      check("rate too fast", rateError, 1);
      $display("rate flag done");
      @(negedge clock) syncClear = 1'b1;
      @(negedge clock) syncClear = 1'b0;
      expN = 4'h0;
      check("clear count", bcdCount, 0);
      check("clear rate", rateError, 0);
      step(MIN_GAP / 2, MIN_GAP / 2);
      step(MIN_GAP / 2, MIN_GAP / 2);
      drain();
      $display("sync clear done");
      @(negedge clock) resetn = 1'b0;
      #1 check("mid reset", bcdCount, 0);
      expN = 4'h0;
      repeat (2) @(negedge clock);
      resetn = 1'b1;
      step(6, 6);
      drain();
      $display("mid reset done");
      endSim();
   end
endmodule : bcd_decade_counter_decoder_tb
